// ### core/swi_ctrl.sv
/*
  sleep, wake-up and interrupt dispatch for a small microcontroller core.
  assumes the core sequencer obeys act/act_addr pulses, stops its own
  oscillator while osc_run is low, and that event inputs are synchronous.
*/
// Function
// - enabled external pin event sets its flag while awake (ignored asleep); next instruction or vector 0x08
// - asleep, pin-change wake and irq enables clear: no wake, no flag
// - asleep, only pin-change irq enable: set flag, stay asleep
// - asleep, only pin-change wake enable: wake, resume next, no flag
// - asleep, both enables, global off: wake, set flag, resume next
// - awake or waking, pin-change irq enabled with global on: set flag, vector 0x08
// - running, pin-change irq enable clear: nothing happens
// - running, pin-change irq enable set: set flag, next if global off
// - timer overflow ignored asleep; enabled overflow sets flag, next or vector
// - comparator enables clear: no wake, no interrupt
// - asleep, only comparator irq enable: set flag, stay asleep
// - asleep, only comparator wake enable: wake and resume next
// - asleep, both comparator enables, global off: wake, set flag, resume next
// - awake or waking, comparator irq enabled, global on: set flag, vector 0x08
// - enabled watchdog time-out resets to 0x00, waking first if asleep
// - low voltage resets to 0x00, waking first if asleep
// - global enable set and cleared by instructions; decides vector on wake
// - sleep stops oscillator and timer; watchdog cleared but keeps running
`timescale 1ns/1ps
module swi_ctrl
  import swi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] port_pins,
  input wire logic comparator_out,
  input wire logic ext_irq_pin0,
  input wire logic ext_irq_pin1,
  input wire logic timer_ovf,
  input wire logic watchdog_timeout,
  input wire logic low_voltage,
  input wire logic [7:0] irq_en_ctrl,
  input wire logic [7:0] wake_en_ctrl,
  input wire logic [7:0] cmp_en_ctrl,
  input wire logic global_irq_on_instr,
  input wire logic global_irq_off_instr,
  input wire logic sleep_instr,
  input wire logic irq_ack,
  input wire logic clr_pinchg_flag,
  input wire logic clr_comparator_flag,
  input wire logic clr_ext_pin0_flag,
  input wire logic clr_ext_pin1_flag,
  input wire logic clr_timer_ovf_flag,
  output logic pinchg_flag,
  output logic comparator_flag,
  output logic ext_pin0_flag,
  output logic ext_pin1_flag,
  output logic timer_ovf_flag,
  output logic global_irq_en,
  output logic asleep,
  output logic osc_run,
  output logic timer_run,
  output logic watchdog_clear,
  output logic [1:0] act,
  output logic [9:0] act_addr
);
  // ****************************************
  // enable decode
  // ****************************************
  logic pinchg_irq_en;
  logic pinchg_wake_en;
  logic comparator_irq_en;
  logic comparator_wake_en;
  logic ext_pin_irq_en;
  logic timer_ovf_irq_en;
  logic watchdog_en;

  assign pinchg_irq_en = irq_en_ctrl[SWI_BIT_PINCHG_IE];
  assign ext_pin_irq_en = irq_en_ctrl[SWI_BIT_EXT_IE];
  assign timer_ovf_irq_en = irq_en_ctrl[SWI_BIT_TIMER_IE];
  assign comparator_irq_en = cmp_en_ctrl[SWI_BIT_CMP_IE];
  assign watchdog_en = cmp_en_ctrl[SWI_BIT_WDT_EN];
  assign pinchg_wake_en = wake_en_ctrl[SWI_BIT_PINCHG_WE];
  assign comparator_wake_en = wake_en_ctrl[SWI_BIT_CMP_WE];

  // ****************************************
  // change detectors
  // ****************************************
  logic pin_change;
  logic cmp_change;
  logic ext0_rise;
  logic ext1_rise;
  logic ext0_chg;
  logic ext1_chg;

  swi_edge #(.W(SWI_PORT_W)) u_pin_edge (
    .clk(clk),
    .rst(rst),
    .level(port_pins),
    .change(pin_change)
  );

  swi_edge #(.W(1)) u_cmp_edge (
    .clk(clk),
    .rst(rst),
    .level(comparator_out),
    .change(cmp_change)
  );

  swi_edge #(.W(1)) u_ext0_edge (
    .clk(clk),
    .rst(rst),
    .level(ext_irq_pin0),
    .change(ext0_chg)
  );

  swi_edge #(.W(1)) u_ext1_edge (
    .clk(clk),
    .rst(rst),
    .level(ext_irq_pin1),
    .change(ext1_chg)
  );

  // external pins trigger on the falling edge
  assign ext0_rise = ext0_chg && !ext_irq_pin0;
  assign ext1_rise = ext1_chg && !ext_irq_pin1;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    swi_state_t pst;
    logic gie;
    logic [1:0] act;
    logic [9:0] addr;
    logic wdclr;
  } swi_st_t;

  swi_st_t st;
  swi_st_t next_st;
  logic sleeping;

  assign sleeping = (st.pst == SWI_ST_SLEEP);

  // ****************************************
  // flag set terms
  // ****************************************
  logic set_pc;
  logic set_cmp;
  logic set_ex0;
  logic set_ex1;
  logic set_tmr;
  logic wake_pc;
  logic wake_cmp;
  logic wake_any;
  logic rst_evt;
  logic pending;

  // pin change flags whenever irq enabled, awake or asleep
  assign set_pc = pin_change && pinchg_irq_en;
  assign set_cmp = cmp_change && comparator_irq_en;
  // external pins and timer are dead in sleep
  assign set_ex0 = !sleeping && ext0_rise && ext_pin_irq_en;
  assign set_ex1 = !sleeping && ext1_rise && ext_pin_irq_en;
  assign set_tmr = !sleeping && timer_ovf && timer_ovf_irq_en;
  // wake only through the wake enables
  assign wake_pc = sleeping && pin_change && pinchg_wake_en;
  assign wake_cmp = sleeping && cmp_change && comparator_wake_en;
  assign wake_any = wake_pc || wake_cmp;
  assign rst_evt = (watchdog_timeout && watchdog_en) || low_voltage;

  swi_flag u_pc_flag (
    .clk(clk),
    .rst(rst),
    .set(set_pc),
    .clr(clr_pinchg_flag),
    .flag(pinchg_flag)
  );

  swi_flag u_cmp_flag (
    .clk(clk),
    .rst(rst),
    .set(set_cmp),
    .clr(clr_comparator_flag),
    .flag(comparator_flag)
  );

  swi_flag u_ex0_flag (
    .clk(clk),
    .rst(rst),
    .set(set_ex0),
    .clr(clr_ext_pin0_flag),
    .flag(ext_pin0_flag)
  );

  swi_flag u_ex1_flag (
    .clk(clk),
    .rst(rst),
    .set(set_ex1),
    .clr(clr_ext_pin1_flag),
    .flag(ext_pin1_flag)
  );

  swi_flag u_tmr_flag (
    .clk(clk),
    .rst(rst),
    .set(set_tmr),
    .clr(clr_timer_ovf_flag),
    .flag(timer_ovf_flag)
  );

  // enabled flag still standing keeps requesting the vector
  assign pending = (pinchg_flag && pinchg_irq_en) || (comparator_flag && comparator_irq_en)
    || ((ext_pin0_flag || ext_pin1_flag) && ext_pin_irq_en)
    || (timer_ovf_flag && timer_ovf_irq_en);

  // ****************************************
  // dispatch: reset beats vector beats next
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.act = SWI_ACT_NONE;
    next_st.wdclr = 1'b0;
    // global enable from instructions; disable wins if both
    if (global_irq_off_instr) begin
      next_st.gie = 1'b0;
    end else if (global_irq_on_instr) begin
      next_st.gie = 1'b1;
    end
    if (rst_evt) begin
      next_st.pst = SWI_ST_RUN;
      next_st.act = SWI_ACT_RESET;
      next_st.addr = SWI_VEC_RESET;
      next_st.gie = 1'b0;
    end else if (sleeping) begin
      if (wake_any) begin
        next_st.pst = SWI_ST_RUN;
        // interrupt only if the waking source also flags it
        if (st.gie && ((wake_pc && pinchg_irq_en) || (wake_cmp && comparator_irq_en))) begin
          next_st.act = SWI_ACT_VECTOR;
          next_st.addr = SWI_VEC_IRQ;
        end else begin
          next_st.act = SWI_ACT_NEXT;
          next_st.addr = SWI_VEC_RESET;
        end
      end
    end else if (sleep_instr) begin
      next_st.pst = SWI_ST_SLEEP;
      next_st.wdclr = 1'b1;
    end else if (st.gie && (pending || set_pc || set_cmp || set_ex0 || set_ex1 || set_tmr)) begin
      if (!irq_ack) begin
        next_st.act = SWI_ACT_VECTOR;
        next_st.addr = SWI_VEC_IRQ;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{pst: SWI_ST_RUN, gie: 1'b0, act: SWI_ACT_NONE, addr: SWI_VEC_RESET, wdclr: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign global_irq_en = st.gie;
  assign asleep = sleeping;
  assign osc_run = !sleeping;
  assign timer_run = !sleeping;
  assign watchdog_clear = st.wdclr;
  assign act = st.act;
  assign act_addr = st.addr;

  // ****************************************
  // checks
  // ****************************************
  property p_ext_flag;
    @(posedge clk) disable iff (rst) set_ex0 |=> ext_pin0_flag;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("ext flag not set");

  property p_no_wake;
    @(posedge clk) disable iff (rst) (sleeping && !pinchg_wake_en && !comparator_wake_en && !rst_evt) |=> sleeping;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woke without wake enable");

  property p_sleep_flag;
    @(posedge clk) disable iff (rst) (sleeping && pin_change && pinchg_irq_en && !clr_pinchg_flag) |=> pinchg_flag;
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("pin change flag lost in sleep");

  property p_wake_next;
    @(posedge clk) disable iff (rst) (wake_pc && !pinchg_irq_en && !(wake_cmp && comparator_irq_en && st.gie)
      && !rst_evt) |=> (act == SWI_ACT_NEXT) && !asleep;
  endproperty
  a_wake_next: assert property (p_wake_next) else $error("wake did not resume next");

  property p_wake_vec;
    @(posedge clk) disable iff (rst)
      (wake_cmp && comparator_irq_en && st.gie && !rst_evt) |=> (act == SWI_ACT_VECTOR) && (act_addr == SWI_VEC_IRQ);
  endproperty
  a_wake_vec: assert property (p_wake_vec) else $error("wake did not vector");

  property p_timer_sleep;
    @(posedge clk) disable iff (rst) sleeping |-> !set_tmr && !timer_run && !osc_run;
  endproperty
  a_timer_sleep: assert property (p_timer_sleep) else $error("timer active in sleep");

  property p_reset;
    @(posedge clk) disable iff (rst) rst_evt |=> (act == SWI_ACT_RESET) && (act_addr == SWI_VEC_RESET) && !asleep;
  endproperty
  a_reset: assert property (p_reset) else $error("reset event not dispatched");

  property p_sleep_entry;
    @(posedge clk) disable iff (rst) (!sleeping && sleep_instr && !rst_evt) |=> asleep && watchdog_clear;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

  property p_gie;
    @(posedge clk) disable iff (rst) (global_irq_off_instr && !rst_evt) |=> !global_irq_en;
  endproperty
  a_gie: assert property (p_gie) else $error("global disable ignored");

  property p_sticky;
    @(posedge clk) disable iff (rst) (pinchg_flag && !clr_pinchg_flag) |=> pinchg_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_run_no_flag;
    @(posedge clk) disable iff (rst)
      (!sleeping && pin_change && !pinchg_irq_en && !pinchg_flag) |=> !pinchg_flag;
  endproperty
  a_run_no_flag: assert property (p_run_no_flag) else $error("pin change flagged while disabled");

  property p_wake_flag;
    @(posedge clk) disable iff (rst)
      (wake_pc && pinchg_irq_en && !st.gie && !rst_evt) |=> (act == SWI_ACT_NEXT) && pinchg_flag && !asleep;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake without flag or next");

  property p_cmp_sleep_flag;
    @(posedge clk) disable iff (rst)
      (sleeping && cmp_change && comparator_irq_en && !comparator_wake_en && !wake_pc && !rst_evt)
      |=> comparator_flag && asleep;
  endproperty
  a_cmp_sleep_flag: assert property (p_cmp_sleep_flag) else $error("comparator flag or sleep lost");

  property p_low_volt;
    @(posedge clk) disable iff (rst)
      low_voltage |=> (act == SWI_ACT_RESET) && (act_addr == SWI_VEC_RESET) && !asleep;
  endproperty
  a_low_volt: assert property (p_low_volt) else $error("low voltage did not reset");

  // running with global enable on and irq_ack low, an enabled external pin or timer event vectors at once
  property p_run_vector;
    @(posedge clk) disable iff (rst)
      (!sleeping && st.gie && (set_ex0 || set_ex1 || set_tmr) && !rst_evt && !sleep_instr && !irq_ack)
      |=> (act == SWI_ACT_VECTOR) && (act_addr == SWI_VEC_IRQ);
  endproperty
  a_run_vector: assert property (p_run_vector) else $error("enabled event did not vector");
endmodule

// ### core/swi_edge.sv
/*
  change detector for a group of input levels.
  assumes inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module swi_edge
  import swi_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] level,
  output logic change
);
  typedef struct packed {
    logic [W-1:0] last;
    logic primed;
  } swi_edge_st_t;

  swi_edge_st_t st;
  swi_edge_st_t next_st;

  // ****************************************
  // remember last level; no change reported on first sample
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.last = level;
    next_st.primed = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign change = st.primed && (level != st.last);
endmodule

// ### core/swi_flag.sv
/*
  sticky interrupt flag: set by hardware event, cleared by software.
  assumes set and clear are single-cycle pulses in the clk domain.
*/
`timescale 1ns/1ps
module swi_flag
  import swi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  typedef struct packed {
    logic f;
  } swi_flag_st_t;

  swi_flag_st_t st;
  swi_flag_st_t next_st;

  // ****************************************
  // set wins over a clear in the same cycle
  // ****************************************
  always_comb begin
    next_st = st;
    if (set) begin
      next_st.f = 1'b1;
    end else if (clr) begin
      next_st.f = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.f;
endmodule

// ### core/swi_pkg.sv
/*
  constants shared by the sleep / wake-up / interrupt dispatch block.
  assumes a single 50 MHz system clock and synchronous active-high reset.
*/
package swi_pkg;
  // ****************************************
  // program addresses and widths
  // ****************************************
  localparam int SWI_ADDR_W = 10;
  localparam logic [9:0] SWI_VEC_IRQ = 10'h008;
  localparam logic [9:0] SWI_VEC_RESET = 10'h000;
  localparam int SWI_PORT_W = 8;

  // ****************************************
  // enable bit positions inside the control bytes
  // ****************************************
  localparam int SWI_BIT_TIMER_IE = 0;
  localparam int SWI_BIT_PINCHG_IE = 1;
  localparam int SWI_BIT_EXT_IE = 2;
  localparam int SWI_BIT_CMP_IE = 0;
  localparam int SWI_BIT_PINCHG_WE = 4;
  localparam int SWI_BIT_CMP_WE = 2;
  localparam int SWI_BIT_WDT_EN = 7;

  // ****************************************
  // sequencer outcome and power state
  // ****************************************
  typedef enum logic [1:0] {
    SWI_ACT_NONE,
    SWI_ACT_NEXT,
    SWI_ACT_VECTOR,
    SWI_ACT_RESET
  } swi_act_t;

  typedef enum logic {
    SWI_ST_RUN,
    SWI_ST_SLEEP
  } swi_state_t;
endpackage

// ### test/sleep_wakeup_interrupt_control_tb_top.sv
/*
  self-checking bench for the sleep / wake-up / interrupt dispatch block.
  assumes the core model in swi_core_model and the swi_pkg constants.
*/
`timescale 1ns/1ps
module sleep_wakeup_interrupt_control_tb_top
  import swi_pkg::*;
  ;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] port_pins = 8'h00;
  logic comparator_out = 1'h0;
  logic ext_irq_pin0 = 1'h1;
  logic ext_irq_pin1 = 1'h1;
  logic timer_ovf = 1'h0;
  logic watchdog_timeout = 1'h0;
  logic low_voltage = 1'h0;
  logic [7:0] irq_en_ctrl = 8'h00;
  logic [7:0] wake_en_ctrl = 8'h00;
  logic [7:0] cmp_en_ctrl = 8'h00;
  logic on_instr = 1'h0;
  logic off_instr = 1'h0;
  logic sleep_instr = 1'h0;
  logic slow = 1'h0;
  logic [4:0] clr = 5'h00;
  logic [4:0] flags;
  logic irq_ack, gie_q, asleep, osc_run, timer_run, watchdog_clear;
  logic [1:0] act;
  logic [9:0] act_addr, pc;
  int err_count = 0;
  int num_checks = 0;

  always #10 clk = ~clk;

  swi_ctrl swi_ctrl_i (.clk(clk), .rst(rst), .port_pins(port_pins), .comparator_out(comparator_out),
    .ext_irq_pin0(ext_irq_pin0), .ext_irq_pin1(ext_irq_pin1), .timer_ovf(timer_ovf),
    .watchdog_timeout(watchdog_timeout), .low_voltage(low_voltage), .irq_en_ctrl(irq_en_ctrl),
    .wake_en_ctrl(wake_en_ctrl), .cmp_en_ctrl(cmp_en_ctrl), .global_irq_on_instr(on_instr),
    .global_irq_off_instr(off_instr), .sleep_instr(sleep_instr), .irq_ack(irq_ack),
    .clr_pinchg_flag(clr[4]), .clr_comparator_flag(clr[3]), .clr_ext_pin0_flag(clr[2]),
    .clr_ext_pin1_flag(clr[1]), .clr_timer_ovf_flag(clr[0]), .pinchg_flag(flags[4]),
    .comparator_flag(flags[3]), .ext_pin0_flag(flags[2]), .ext_pin1_flag(flags[1]),
    .timer_ovf_flag(flags[0]), .global_irq_en(gie_q), .asleep(asleep), .osc_run(osc_run),
    .timer_run(timer_run), .watchdog_clear(watchdog_clear), .act(act), .act_addr(act_addr));

  swi_core_model swi_core_model_i (.clk(clk), .slow(slow), .act(act), .act_addr(act_addr),
    .irq_ack(irq_ack), .pc(pc));

  // ****************************************
  // helpers
  // ****************************************
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // outcome for one event: s 0 pin, 1 cmp, 2 ext0, 3 ext1, 4 timer, 5 wdt, 6 low voltage
  function automatic logic [1:0] exp_act(int s, logic slp, logic ie, logic we, logic gie);
    if (s == 6 || (s == 5 && ie)) return SWI_ACT_RESET;
    if (s == 5 || (slp && (s > 1 || !we))) return SWI_ACT_NONE;
    // awake with global enable off the core just runs on: no outcome
    if (!ie || !gie) return slp ? SWI_ACT_NEXT : SWI_ACT_NONE;
    return SWI_ACT_VECTOR;
  endfunction

  // ****************************************
  // every source against every enable, sleep and global setting
  // ****************************************
  initial begin
    int s;
    int k;
    logic slp, ie, we, gie;
    logic [1:0] ea;
    logic [4:0] ef;
    k = $urandom(32'h0000_ce4c);
    repeat (10) @(posedge clk);
    #1 rst = 1'h0;
    for (s = 0; s < 7; s++) begin
      for (k = 0; k < 16; k++) begin
        {slp, ie, we, gie} = 4'(k);
        slow = 1'($urandom);
        rst = 1'h1;
        step();
        rst = 1'h0;
        repeat (3) step();
        // random unrelated bits, then the enables under test
        irq_en_ctrl = 8'($urandom);
        wake_en_ctrl = 8'($urandom);
        cmp_en_ctrl = 8'($urandom);
        irq_en_ctrl[SWI_BIT_TIMER_IE] = ie;
        irq_en_ctrl[SWI_BIT_PINCHG_IE] = ie;
        irq_en_ctrl[SWI_BIT_EXT_IE] = ie;
        cmp_en_ctrl[SWI_BIT_CMP_IE] = ie;
        cmp_en_ctrl[SWI_BIT_WDT_EN] = ie;
        wake_en_ctrl[SWI_BIT_PINCHG_WE] = we;
        wake_en_ctrl[SWI_BIT_CMP_WE] = we;
        on_instr = 1'h1;
        off_instr = !gie;
        step();
        {on_instr, off_instr} = 2'h0;
        chk("gie", 10'(gie_q), 10'(gie));
        if (slp) begin
          sleep_instr = 1'h1;
          step();
          sleep_instr = 1'h0;
          chk("osc_timer", 10'({asleep, osc_run, timer_run}), 10'h004);
          if (ie) chk("wdt_clear", 10'(watchdog_clear), 10'h001);
          step();
        end
        case (s)
          0: port_pins = port_pins ^ 8'(1 + $urandom % 255);
          1: comparator_out = ~comparator_out;
          2: ext_irq_pin0 = 1'h0;
          3: ext_irq_pin1 = 1'h0;
          4: timer_ovf = 1'h1;
          5: watchdog_timeout = 1'h1;
          default: low_voltage = 1'h1;
        endcase
        step();
        {ext_irq_pin0, ext_irq_pin1} = 2'h3;
        {timer_ovf, watchdog_timeout, low_voltage} = 3'h0;
        ea = exp_act(s, slp, ie, we, gie);
        ef = (s < 5 && ie && !(slp && s > 1)) ? 5'(5'h10 >> s) : 5'h00;
        chk("act", 10'(act), 10'(ea));
        chk("addr", act_addr, ea == 2'h2 ? SWI_VEC_IRQ : SWI_VEC_RESET);
        chk("flags", 10'(flags), 10'(ef));
        chk("asleep", 10'({asleep, osc_run}), 10'(slp && ea == 2'h0 ? 2'h2 : 2'h1));
        step();
        if (ea == 2'h2 && !slow) chk("act_again", 10'(act), 10'h002);
        if (ea > 2'h1) chk("pc", pc, ea == 2'h2 ? SWI_VEC_IRQ : SWI_VEC_RESET);
        chk("flag_hold", 10'(flags), 10'(ef));
        clr = ef;
        step();
        clr = 5'h00;
        chk("flag_clr", 10'(flags), 10'h000);
        if (ea == 2'h2) chk("act_ack", 10'(act), slow ? 10'h000 : 10'h002);
      end
    end
    close_out();
  end

  // cut a hang short well past the expected run length
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule

// ### test/swi_core_model.sv
/*
  model of the core sequencer that obeys the dispatch outcome.
  assumes act is a one-cycle registered pulse in the clk domain.
*/
`timescale 1ns/1ps
module swi_core_model
  import swi_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  input wire logic [1:0] act,
  input wire logic [9:0] act_addr,
  output logic irq_ack,
  output logic [9:0] pc
);
  // pc survives rst on purpose so that a jump to 0x000 can be seen
  initial pc = 10'h155;
  initial irq_ack = 1'h0;
  // follow the outcome; a slow core raises irq_ack a cycle after a vector, holding off further vector requests
  always @(posedge clk) begin
    irq_ack <= slow && (act == SWI_ACT_VECTOR);
    if (act == SWI_ACT_NEXT) begin
      pc <= pc + 10'h001;
    end else if (act != SWI_ACT_NONE) begin
      pc <= act_addr;
    end
  end
endmodule
